// ===== design/tcs_chan_sel.sv
// Purpose: Count-enable selector for one channel.
// Assumes: Tap and pin edges arrive as one-cycle pulses on hclk.
// Notes: The source table differs per channel and is fixed by CH.
`default_nettype none

module tcs_chan_sel #(
  parameter int CH = 0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire tcs_pkg::tcs_chcfg_s cfg,
  input wire logic phase_mode,
  input wire logic [tcs_pkg::NTAP-1:0] tap_rise,
  input wire logic [tcs_pkg::NTAP-1:0] tap_fall,
  input wire logic [3:0] ext_rise,
  input wire logic [3:0] ext_fall,
  input wire logic partner_wrap,
  output logic count_en
);
  import tcs_pkg::*;

  tcs_src_e kind;
  logic [2:0] idx;
  logic next_count_en;

  function automatic logic pick(input logic r, input logic f,
                                input logic [1:0] e);
    pick = e[1] ? (r | f) : (e[0] ? f : r);
  endfunction

  // ************************************************************
  // Source decode
  // ************************************************************
  always_comb begin
    kind = SRC_DIV1;
    idx = 3'd0;
    if (!cfg.clk_sel[2]) begin
      if (cfg.clk_sel[1:0] != 2'b00) begin
        kind = SRC_TAP;
        idx = {1'b0, cfg.clk_sel[1:0]} - 3'd1;
      end
    end else begin
      kind = SRC_EXT;
      idx = {1'b0, cfg.clk_sel[1:0]};
      case (CH)
        1: begin
          if (cfg.clk_sel[1:0] == 2'b10) begin
            kind = SRC_TAP;
            idx = TAP_256;
          end else if (cfg.clk_sel[1:0] == 2'b11) begin
            kind = SRC_PARTNER;
          end
        end
        2: begin
          if (cfg.clk_sel[1:0] == 2'b11) begin
            kind = SRC_TAP;
            idx = TAP_1024;
          end
        end
        3: begin
          case (cfg.clk_sel[1:0])
            2'b01: begin
              kind = SRC_TAP;
              idx = TAP_1024;
            end
            2'b10: begin
              kind = SRC_TAP;
              idx = TAP_256;
            end
            2'b11: begin
              kind = SRC_TAP;
              idx = TAP_4096;
            end
            default: idx = 3'd0;
          endcase
        end
        4: begin
          case (cfg.clk_sel[1:0])
            2'b01: idx = 3'd2;
            2'b10: begin
              kind = SRC_TAP;
              idx = TAP_1024;
            end
            2'b11: kind = SRC_PARTNER;
            default: idx = 3'd0;
          endcase
        end
        5: begin
          case (cfg.clk_sel[1:0])
            2'b01: idx = 3'd2;
            2'b10: begin
              kind = SRC_TAP;
              idx = TAP_256;
            end
            2'b11: idx = 3'd3;
            default: idx = 3'd0;
          endcase
        end
        default: idx = {1'b0, cfg.clk_sel[1:0]};
      endcase
    end
  end

  // ************************************************************
  // Count-enable pulse
  // ************************************************************
  // Undivided and partner sources pass straight; edge choice is ignored.
  always_comb begin
    case (kind)
      SRC_DIV1: next_count_en = 1'b1;
      SRC_TAP: next_count_en = pick(tap_rise[idx], tap_fall[idx],
                                    cfg.edge_sel);
      SRC_EXT: next_count_en = pick(ext_rise[idx[1:0]], ext_fall[idx[1:0]],
                                    cfg.edge_sel);
      SRC_PARTNER: next_count_en = partner_wrap;
      default: next_count_en = 1'b0;
    endcase
    if (phase_mode) begin
      next_count_en = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_en <= 1'b0;
    end else begin
      count_en <= next_count_en;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Sampled reset keeps the release edge out; the pulse is still low there.
  a_div1_every_cycle: assert property (
    hresetn && cfg.clk_sel == 3'b000 && !phase_mode |=> count_en)
    else $error("undivided source did not count");
  a_phase_quiet: assert property (
    phase_mode |=> !count_en)
    else $error("count while in phase counting mode");
  a_ch0_pin_d: assert property (
    CH == 0 && cfg.clk_sel == 3'b111 && cfg.edge_sel == 2'b00
    && !phase_mode |=> count_en == $past(ext_rise[3]))
    else $error("channel 0 pin D not followed");
  a_partner_wrap: assert property (
    (CH == 1 || CH == 4) && cfg.clk_sel == 3'b111 && !phase_mode
    |=> count_en == $past(partner_wrap))
    else $error("partner wrap not followed");
  a_ch2_div1024: assert property (
    CH == 2 && cfg.clk_sel == 3'b111 && cfg.edge_sel == 2'b01
    && !phase_mode |=> count_en == $past(tap_fall[4]))
    else $error("channel 2 div 1024 not followed");
  a_ch3_div4096: assert property (
    CH == 3 && cfg.clk_sel == 3'b111 && cfg.edge_sel == 2'b00
    && !phase_mode |=> count_en == $past(tap_rise[5]))
    else $error("channel 3 div 4096 not followed");
  a_ch4_pin_c: assert property (
    CH == 4 && cfg.clk_sel == 3'b101 && cfg.edge_sel[1]
    && !phase_mode |=> count_en == $past(ext_rise[2] | ext_fall[2]))
    else $error("channel 4 pin C both edges not followed");
  a_ch5_div256: assert property (
    CH == 5 && cfg.clk_sel == 3'b110 && cfg.edge_sel == 2'b00
    && !phase_mode |=> count_en == $past(tap_rise[3]))
    else $error("channel 5 div 256 not followed");
  c_partner_count: cover property (
    kind == SRC_PARTNER && partner_wrap && !phase_mode ##1 count_en);
  c_ext_count: cover property (
    kind == SRC_EXT && !phase_mode ##1 count_en);

endmodule : tcs_chan_sel

`default_nettype wire

// ===== design/tcs_pkg.sv
// Purpose: Constants and types for the timer count-clock selector.
// Assumes: One 50 MHz clock, one free-running prescaler for all channels.
// Notes: Tap indices follow the divide ratios from 4 up to 4096.
// Function
// - Codes 000 to 011 count on the clock divided by 1, 4, 16, 64.
// - Channel 0 codes 100 to 111 count on external pins A, B, C, D.
// - Channel 1 codes 100/101 pins A/B, 110 div 256, 111 channel 2 wrap.
// - Channel 2 codes 100 to 110 pins A, B, C and 111 div 1024.
// - Channel 3 code 100 pin A and 101/110/111 div 1024, 256, 4096.
// - Channel 4 codes 100/101 pins A/C, 110 div 1024, 111 channel 5 wrap.
// - Channel 5 codes 100/101/111 pins A/C/D and 110 div 256.
// - Channels 1, 2, 4, 5 in phase counting mode ignore the selection.
// - Each control register reads zero after reset and in standby.
// - Edge choice acts on div 4 and slower and on pins, not elsewhere.
`default_nettype none

package tcs_pkg;

  // ************************************************************
  // Sizes and register map
  // ************************************************************
  localparam int NCH = 6;
  localparam int NTAP = 6;
  localparam int DIV_W = 12;
  localparam logic [7:0] CTRL_BASE = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h18;
  localparam logic [7:0] STAT_OFS = 8'h1C;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [7:0] CTRL_MASK_FULL = 8'hFF;
  localparam logic [7:0] CTRL_MASK_RSVD7 = 8'h7F;
  localparam logic [5:0] PHASE_CAP = 6'b11_0110;
  localparam int SEL_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int STAT_EN_LSB = 16;

  // ************************************************************
  // Prescaler taps: log2 of the divide ratios 4 to 4096
  // ************************************************************
  localparam int TAP_LOG2 [NTAP] = '{2, 4, 6, 8, 10, 12};
  localparam logic [2:0] TAP_256 = 3'd3;
  localparam logic [2:0] TAP_1024 = 3'd4;
  localparam logic [2:0] TAP_4096 = 3'd5;

  typedef enum logic [1:0] {SRC_DIV1, SRC_TAP, SRC_EXT, SRC_PARTNER} tcs_src_e;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic [2:0] clk_sel;
  } tcs_chcfg_s;

endpackage : tcs_pkg

`default_nettype wire

// ===== design/tcs_top.sv
// Purpose: Six-channel count-clock selector with an AHB-Lite register port.
// Assumes: Pins A to D are asynchronous; wrap inputs and standby are on hclk.
// Notes: Zero wait states; every access answers OKAY.
`default_nettype none

module tcs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hw_standby,
  input wire logic ext_count_pin_a,
  input wire logic ext_count_pin_b,
  input wire logic ext_count_pin_c,
  input wire logic ext_count_pin_d,
  input wire logic [tcs_pkg::NCH-1:0] counter_wrap,
  output logic [tcs_pkg::NCH-1:0] phase_mode,
  output logic [tcs_pkg::NCH-1:0] count_en
);
  import tcs_pkg::*;

  logic [7:0] channel_control_reg [NCH];
  logic [7:0] next_ctrl [NCH];
  logic [5:0] next_mode;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [DIV_W-1:0] div_cnt;
  logic [NTAP-1:0] tap_rise;
  logic [NTAP-1:0] tap_fall;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] ext_rise;
  logic [3:0] ext_fall;
  logic addr_ok;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;

  // ************************************************************
  // Register file
  // ************************************************************
  // A read right behind a write to the same word sees the new value,
  // because the read mux looks at the next state.
  always_comb begin
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_mode = phase_mode;
    for (int i = 0; i < NCH; i++) begin
      next_ctrl[i] = channel_control_reg[i];
      if (wr_pend && wr_addr == CTRL_BASE + 8'(4 * i)) begin
        next_ctrl[i] = hwdata[7:0]
          & (PHASE_CAP[i] ? CTRL_MASK_RSVD7 : CTRL_MASK_FULL);
      end
    end
    if (wr_pend && wr_addr == MODE_OFS) begin
      next_mode = hwdata[5:0] & PHASE_CAP;
    end
    // Standby is applied last, so it wins over a write in the same cycle.
    if (hw_standby) begin
      for (int i = 0; i < NCH; i++) begin
        next_ctrl[i] = CTRL_RST;
      end
      next_mode = MODE_RST;
    end
    next_hrdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      for (int i = 0; i < NCH; i++) begin
        if (haddr[7:0] == CTRL_BASE + 8'(4 * i)) begin
          next_hrdata = {24'h00_0000, next_ctrl[i]};
        end
      end
      if (haddr[7:0] == MODE_OFS) begin
        next_hrdata = {26'h000_0000, next_mode};
      end
      if (haddr[7:0] == STAT_OFS) begin
        next_hrdata = 32'h0000_0000;
        next_hrdata[DIV_W-1:0] = div_cnt;
        next_hrdata[STAT_EN_LSB +: NCH] = count_en;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        channel_control_reg[i] <= CTRL_RST;
      end
      phase_mode <= MODE_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        channel_control_reg[i] <= next_ctrl[i];
      end
      phase_mode <= next_mode;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // ************************************************************
  // Shared prescaler and pin synchronisers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= '0;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
      pin_s1 <= {ext_count_pin_d, ext_count_pin_c,
                 ext_count_pin_b, ext_count_pin_a};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Only the second stage and its delayed copy feed the edge logic; the
  // first stage may still be settling from a metastable sample.
  assign ext_rise = pin_s2 & ~pin_s3;
  assign ext_fall = ~pin_s2 & pin_s3;

  // The divided clock is a virtual square wave on a counter bit; a tap
  // pulses in the cycle before that bit would rise or fall.
  for (genvar t = 0; t < NTAP; t++) begin : g_tap
    localparam logic [DIV_W-1:0] MASK = DIV_W'((1 << TAP_LOG2[t]) - 1);
    assign tap_rise[t] = (div_cnt & MASK) == (MASK >> 1);
    assign tap_fall[t] = (div_cnt & MASK) == MASK;
  end

  // ************************************************************
  // Channel selectors
  // ************************************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    tcs_chcfg_s cfg;
    logic partner;
    assign cfg = {channel_control_reg[c][EDGE_LSB +: 2],
                  channel_control_reg[c][SEL_LSB +: 3]};
    assign partner = (c == 1) ? counter_wrap[2] :
                     (c == 4) ? counter_wrap[5] : 1'b0;
    tcs_chan_sel #(.CH(c)) u_sel (
      .hclk(hclk),
      .hresetn(hresetn),
      .cfg(cfg),
      .phase_mode(phase_mode[c]),
      .tap_rise(tap_rise),
      .tap_fall(tap_fall),
      .ext_rise(ext_rise),
      .ext_fall(ext_fall),
      .partner_wrap(partner),
      .count_en(count_en[c])
    );
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_standby_clears: assert property (
    hw_standby |=> channel_control_reg[0] == CTRL_RST
    && channel_control_reg[5] == CTRL_RST && phase_mode == MODE_RST)
    else $error("standby did not clear control");
  a_tap4_period: assert property (
    tap_rise[0] |=> !tap_rise[0] [*3] ##1 tap_rise[0])
    else $error("divide by 4 tap period wrong");
  a_tap4_half: assert property (
    tap_rise[0] |-> ##2 tap_fall[0])
    else $error("divide by 4 fall not two cycles after rise");
  a_pin_sync_delay: assert property (
    ext_rise[0] |-> $past(ext_count_pin_a, 2)
    && !$past(ext_count_pin_a, 3))
    else $error("pin A edge not two stages late");
  a_phase_mask: assert property (
    !phase_mode[0] && !phase_mode[3])
    else $error("phase mode set on a channel without it");
  // The first check below also watches the read path, where a wrong word would
  // otherwise only show up in software.
  a_read_ctrl0: assert property (
    addr_ok && !hwrite && haddr[7:0] == CTRL_BASE && !wr_pend && !hw_standby
    |=> hrdata == {24'h00_0000, $past(channel_control_reg[0])})
    else $error("control 0 read back wrong");
  a_rsvd_bit_low: assert property (
    !channel_control_reg[1][7] && !channel_control_reg[2][7]
    && !channel_control_reg[4][7] && !channel_control_reg[5][7])
    else $error("reserved control bit set");
  a_tap4_fall_rise: assert property (
    tap_fall[0] |-> ##2 tap_rise[0])
    else $error("divide by 4 rise not two cycles after fall");
  a_tap16_half: assert property (
    tap_rise[1] |-> ##8 tap_fall[1])
    else $error("divide by 16 fall not eight cycles after rise");
  a_pin_fall_delay: assert property (
    ext_fall[0] |-> !$past(ext_count_pin_a, 2)
    && $past(ext_count_pin_a, 3))
    else $error("pin A fall not two stages late");
  a_wrap_to_ch1: assert property (
    counter_wrap[2] && channel_control_reg[1][SEL_LSB +: 3] == 3'b111
    && !phase_mode[1] |=> count_en[1])
    else $error("channel 2 wrap did not count channel 1");
  a_mode_write: assert property (
    wr_pend && wr_addr == MODE_OFS && !hw_standby
    |=> phase_mode == ($past(hwdata[5:0]) & PHASE_CAP))
    else $error("phase mode write not masked");
  c_tap4096: cover property (tap_rise[5]);
  c_phase_ch1: cover property (phase_mode[1]);
  c_standby_phase: cover property (hw_standby && phase_mode[2]);

endmodule : tcs_top

`default_nettype wire

// ===== tb/tcs_tb.sv
// Purpose: Self-checking bench for the six-channel count-clock selector.
// Assumes: Zero-wait AHB-Lite slave, hready tied back from hreadyout.
// Notes: Divide ratios are timed as the gap between count-enable pulses.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tcs_pkg::*;

  // ************************************************************
  // Signals, clock and design
  // ************************************************************
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic hw_standby;
  logic [3:0] pins;
  logic [NCH-1:0] counter_wrap;
  logic [NCH-1:0] phase_mode;
  logic [NCH-1:0] count_en;
  int miscompares;
  int checks_done;
  int cycles;
  int n;
  logic [31:0] rv;
  logic [31:0] rv2;

  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  tcs_top tcs_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hw_standby(hw_standby),
    .ext_count_pin_a(pins[0]), .ext_count_pin_b(pins[1]),
    .ext_count_pin_c(pins[2]), .ext_count_pin_d(pins[3]),
    .counter_wrap(counter_wrap), .phase_mode(phase_mode),
    .count_en(count_en)
  );

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The slow dividers set the ceiling; 4096 is waited for three times.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      finish_test();
    end
  end

  // ************************************************************
  // Bus and observation tasks
  // ************************************************************
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    check(what, exp, v);
  endtask

  // The first gap after a switch may be short, so two are skipped.
  task automatic gap(input int ch, output int g);
    for (int k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(negedge hclk);
        g++;
      end while (count_en[ch] !== 1'b1 && g < 10000);
    end
  endtask

  task automatic cnt(input int ch, input int len, output int c);
    c = 0;
    repeat (len) begin
      @(negedge hclk);
      if (count_en[ch] === 1'b1) c++;
    end
  endtask

  // ************************************************************
  // Tables of sources
  // ************************************************************
  int dv_ch [10] = '{1, 2, 3, 3, 3, 4, 5, 3, 3, 3};
  int dv_cfg [10] = '{6, 'h0f, 5, 6, 7, 6, 6, 'h12, 'h10, 'h0a};
  int dv_n [10] = '{256, 1024, 1024, 256, 4096, 1024, 256, 8, 1, 16};
  int pn_ch [15] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 3, 4, 4, 5, 5, 5};
  int pn_code [15] = '{4, 5, 6, 7, 4, 5, 4, 5, 6, 4, 4, 'h15, 4, 5, 7};
  int pn_pin [15] = '{0, 1, 2, 3, 0, 1, 0, 1, 2, 0, 0, 2, 0, 2, 3};

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    hw_standby = 1'b0;
    pins = 4'h0;
    counter_wrap = 6'h00;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      rd_chk("ctrl reset", 4 * c, 32'h0000_0000);
    end
    rd_chk("mode reset", MODE_OFS, 32'h0000_0000);
    rd_chk("unmapped", 32'h0000_0020, 32'h0000_0000);
    gap(0, n);
    check("reset source gap", 1, n);
    wr(32'h0000_0000, 32'h0000_00ff);
    wr(32'h0000_0004, 32'h0000_00ff);
    rd_chk("ctrl0 full", 32'h0000_0000, 32'h0000_00ff);
    rd_chk("ctrl1 bit7", 32'h0000_0004, 32'h0000_007f);
    for (int c = 0; c < NCH; c++) begin
      for (int s = 0; s < 4; s++) begin
        wr(4 * c, s);
        gap(c, n);
        check("low code gap", 1 << (2 * s), n);
      end
    end
    for (int i = 0; i < 10; i++) begin
      wr(4 * dv_ch[i], dv_cfg[i]);
      gap(dv_ch[i], n);
      check("divider gap", dv_n[i], n);
    end
    // Other pins move first, so a wrong pin choice shows as a pulse.
    for (int i = 0; i < 15; i++) begin
      wr(4 * pn_ch[i], pn_code[i]);
      repeat (4) @(posedge hclk);
      pins <= ~(4'h1 << pn_pin[i]);
      cnt(pn_ch[i], 8, n);
      check("other pins", 0, n);
      @(posedge hclk);
      pins <= 4'hf;
      cnt(pn_ch[i], 8, n);
      check("pin rise", 1, n);
      @(posedge hclk);
      pins <= 4'h0;
      cnt(pn_ch[i], 8, n);
      check("pin fall", pn_code[i] >> 4, n);
    end
    for (int i = 0; i < 2; i++) begin
      wr(4 * (1 + 3 * i), 32'h0000_0007);
      repeat (4) @(posedge hclk);
      counter_wrap <= ~(6'h04 << (3 * i));
      @(posedge hclk);
      counter_wrap <= 6'h00;
      cnt(1 + 3 * i, 6, n);
      check("wrong wrap", 0, n);
      @(posedge hclk);
      counter_wrap <= 6'h04 << (3 * i);
      @(posedge hclk);
      counter_wrap <= 6'h00;
      cnt(1 + 3 * i, 6, n);
      check("partner wrap", 1, n);
    end
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0000);
    wr(MODE_OFS, 32'h0000_003f);
    rd_chk("mode capable", MODE_OFS, 32'h0000_0036);
    check("phase flags", 32'h0000_0036, phase_mode);
    cnt(1, 20, n);
    check("phase ch1 held", 0, n);
    cnt(0, 20, n);
    check("ch0 runs", 20, n);
    wr(MODE_OFS, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    cnt(1, 20, n);
    check("ch1 resumes", 20, n);
    wr(32'h0000_0008, 32'h0000_0001);
    wr(MODE_OFS, 32'h0000_0004);
    rd_chk("mode ch2 set", MODE_OFS, 32'h0000_0004);
    @(posedge hclk);
    hw_standby <= 1'b1;
    @(posedge hclk);
    hw_standby <= 1'b0;
    rd_chk("standby ctrl2", 32'h0000_0008, 32'h0000_0000);
    rd_chk("standby mode", MODE_OFS, 32'h0000_0000);
    wr(32'h0000_000c, 32'h0000_0005);
    rd_chk("ctrl3 set", 32'h0000_000c, 32'h0000_0005);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("second reset", 32'h0000_000c, 32'h0000_0000);
    ahb(1'b0, STAT_OFS, 32'h0000_0000, rv);
    ahb(1'b0, STAT_OFS, 32'h0000_0000, rv2);
    check("status enables", 32'h0000_003f, rv[STAT_EN_LSB +: NCH]);
    check("prescaler step", 32'h0000_0003,
          DIV_W'(rv2[DIV_W-1:0] - rv[DIV_W-1:0]));
    finish_test();
  end

endmodule // tb

`default_nettype wire
